// file: pldc_pkg.sv
// How it works
// - loopback bit routes scrambler output straight into descrambler input
// - in loopback collision stays low unless collision test is set
// - loopback sends nothing to the line and powers transmitters down
// - crossover reported in two fields, pair 0:1 and pair 2:3
// - inverted polarity corrected per channel, shown in four status bits
// - channel one polarity bit valid only after negotiation completes
// - channels zero, two, three polarity bits valid only with link up
// - good received packets counted in 48 bits over low, mid, high
// - low read of good counter snapshots mid and high parts
// - high read of good counter subtracts the value taken at the low read
// - crc errors counted in 48 bits over low, mid, high
// - low read of crc counter snapshots mid and high parts
// - high read of crc counter subtracts the value taken at the low read
// - receive errors during data counted in a 16-bit register
// - receive errors during idle counted in a separate 16-bit register
// - transmitted packets counted in 48 bits over low, mid, high
// - low read of transmit counter snapshots mid and high parts
// - high read of transmit counter subtracts the value taken at the low read
// - collision test: collision within 512 bit times, drops within 4; code drops it 100 ns after tx_en falls, within 4 only up to 40 Mb/s
package pldc_pkg;
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_STATUS    = 12'h004;
  localparam logic [11:0] OFF_GOOD_LO   = 12'h010;
  localparam logic [11:0] OFF_GOOD_MID  = 12'h014;
  localparam logic [11:0] OFF_GOOD_HI   = 12'h018;
  localparam logic [11:0] OFF_CRC_LO    = 12'h020;
  localparam logic [11:0] OFF_CRC_MID   = 12'h024;
  localparam logic [11:0] OFF_CRC_HI    = 12'h028;
  localparam logic [11:0] OFF_TX_LO     = 12'h030;
  localparam logic [11:0] OFF_TX_MID    = 12'h034;
  localparam logic [11:0] OFF_TX_HI     = 12'h038;
  localparam logic [11:0] OFF_RXE_DATA  = 12'h040;
  localparam logic [11:0] OFF_RXE_IDLE  = 12'h044;
  // control field positions
  localparam int CTRL_LOOPBACK = 0;
  localparam int CTRL_COL_TEST = 1;
  // status field positions
  localparam int ST_POL_LSB  = 0;
  localparam int ST_XA_LSB   = 4;
  localparam int ST_XB_LSB   = 6;
  localparam int ST_LINK     = 8;
  localparam int ST_AN_DONE  = 9;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int COUNT_RESET = 0;
  // collision-test timing; one 100 ns cycle is well inside 512 bit times at any speed, but inside 4 bit times only up to 40 Mb/s
  localparam int COL_ASSERT_BITS  = 512;
  localparam int COL_RELEASE_BITS = 4;
  localparam int CLK_NS = 100;
  localparam int COL_DELAY_CYC = 1;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic [3:0] pol_flip;
    logic [1:0] crossed_pair_a_status;
    logic [1:0] crossed_pair_b_status;
    logic       link_up;
    logic       an_done;
  } pldc_status_t;

  typedef struct packed {
    logic       good_pkt;
    logic       crc_err;
    logic       tx_pkt;
    logic       rxerr_data;
    logic       rxerr_idle;
  } pldc_events_t;
endpackage

// file: pldc_diag.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module pldc_diag #(
  parameter int WIDE = 48,
  parameter int NARROW = 16
) (
  input  wire logic                  pclk,        // 10 MHz bus clock
  input  wire logic                  presetn,     // async reset, low
  input  wire logic                  psel,        // apb select
  input  wire logic                  penable,     // apb enable
  input  wire logic                  pwrite,      // apb direction
  input  wire logic [11:0]           paddr,       // apb byte address
  input  wire logic [31:0]           pwdata,      // apb write data
  output logic      [31:0]           prdata,      // apb read data
  output logic                       pready,      // apb ready
  output logic                       pslverr,     // apb error
  input  wire logic [7:0]            scr_data,    // scrambler output
  input  wire logic [7:0]            line_rx,     // data from line receiver
  output logic      [7:0]            descr_in,    // descrambler input
  output logic      [7:0]            line_tx,     // data to line driver
  output logic                       tx_power_dn, // line transmitters off
  input  wire logic                  tx_en,       // mac transmit enable
  input  wire logic                  col_raw,     // line collision detector
  output logic                       col,         // collision to mac
  input  wire pldc_pkg::pldc_status_t stat_in,    // pma status levels
  input  wire pldc_pkg::pldc_events_t events      // one-cycle count strobes
);
  logic [1:0]  ctrl;
  logic        loopback;
  logic        col_test;
  logic        access;
  logic        rd_acc;
  logic        rd_set;
  logic [2:0]  rd_lo;
  logic [2:0]  rd_hi;
  logic [WIDE-1:0]   cnt   [3];
  logic [WIDE-17:0]  snap  [3];
  logic [NARROW-1:0] err_data;
  logic [NARROW-1:0] err_idle;
  logic [2:0]  wide_ev;
  logic [9:0]  status_word;
  localparam int COL_W = 4;
  logic [COL_W-1:0] col_cnt;

  assign loopback = ctrl[pldc_pkg::CTRL_LOOPBACK];
  assign col_test = ctrl[pldc_pkg::CTRL_COL_TEST];
  assign access   = psel & penable;
  assign rd_acc   = access & ~pwrite;
  assign rd_set   = psel & ~penable & ~pwrite;
  assign wide_ev  = {events.tx_pkt, events.crc_err, events.good_pkt};

  // snapshot at the setup edge, the same edge that loads the low part into
  // prdata, so an event in the setup cycle is not subtracted unreported
  assign rd_lo = {rd_set && paddr == pldc_pkg::OFF_TX_LO,
                  rd_set && paddr == pldc_pkg::OFF_CRC_LO,
                  rd_set && paddr == pldc_pkg::OFF_GOOD_LO};
  assign rd_hi = {rd_acc && paddr == pldc_pkg::OFF_TX_HI,
                  rd_acc && paddr == pldc_pkg::OFF_CRC_HI,
                  rd_acc && paddr == pldc_pkg::OFF_GOOD_HI};

  function automatic logic [NARROW-1:0] sat_inc16(input logic [NARROW-1:0] v);
    sat_inc16 = (&v) ? v : v + 1'b1;
  endfunction

  // polarity bits are gated until their qualifying status is reached
  always_comb begin
    status_word = '0;
    status_word[pldc_pkg::ST_POL_LSB+1] = stat_in.pol_flip[1] & stat_in.an_done;
    status_word[pldc_pkg::ST_POL_LSB+0] = stat_in.pol_flip[0] & stat_in.link_up;
    status_word[pldc_pkg::ST_POL_LSB+2] = stat_in.pol_flip[2] & stat_in.link_up;
    status_word[pldc_pkg::ST_POL_LSB+3] = stat_in.pol_flip[3] & stat_in.link_up;
    status_word[pldc_pkg::ST_XA_LSB +: 2] = stat_in.crossed_pair_a_status;
    status_word[pldc_pkg::ST_XB_LSB +: 2] = stat_in.crossed_pair_b_status;
    status_word[pldc_pkg::ST_LINK]   = stat_in.link_up;
    status_word[pldc_pkg::ST_AN_DONE] = stat_in.an_done;
  end

  // control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= pldc_pkg::CTRL_RESET;
    end else if (access && pwrite && paddr == pldc_pkg::OFF_CTRL) begin
      ctrl <= pwdata[1:0];
    end
  end

  // apb answers in the access cycle's next edge; no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= pldc_pkg::UNMAPPED_DATA;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          pldc_pkg::OFF_CTRL:     prdata <= {30'h0, ctrl};
          pldc_pkg::OFF_STATUS:   prdata <= {22'h0, status_word};
          pldc_pkg::OFF_GOOD_LO:  prdata <= {16'h0, cnt[0][15:0]};
          pldc_pkg::OFF_GOOD_MID: prdata <= {16'h0, snap[0][15:0]};
          pldc_pkg::OFF_GOOD_HI:  prdata <= {16'h0, snap[0][31:16]};
          pldc_pkg::OFF_CRC_LO:   prdata <= {16'h0, cnt[1][15:0]};
          pldc_pkg::OFF_CRC_MID:  prdata <= {16'h0, snap[1][15:0]};
          pldc_pkg::OFF_CRC_HI:   prdata <= {16'h0, snap[1][31:16]};
          pldc_pkg::OFF_TX_LO:    prdata <= {16'h0, cnt[2][15:0]};
          pldc_pkg::OFF_TX_MID:   prdata <= {16'h0, snap[2][15:0]};
          pldc_pkg::OFF_TX_HI:    prdata <= {16'h0, snap[2][31:16]};
          pldc_pkg::OFF_RXE_DATA: prdata <= {16'h0, err_data};
          pldc_pkg::OFF_RXE_IDLE: prdata <= {16'h0, err_idle};
          default:                prdata <= pldc_pkg::UNMAPPED_DATA;
        endcase
      end
    end
  end

  // wide counters: low read snapshots upper parts and subtracts the reported
  // value on the high read, so events after the snapshot are kept
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_wide
      logic [WIDE-1:0] taken;
      logic [WIDE-1:0] next_cnt;
      always_comb begin
        next_cnt = cnt[g];
        if (rd_hi[g]) begin
          next_cnt = cnt[g] - taken;
        end
        if (wide_ev[g] && !(&next_cnt)) begin
          next_cnt = next_cnt + 1'b1;
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt[g]  <= '0;
          snap[g] <= '0;
          taken   <= '0;
        end else begin
          cnt[g] <= next_cnt;
          if (rd_lo[g]) begin
            snap[g] <= cnt[g][WIDE-1:16];
            taken   <= cnt[g];
          end else if (rd_hi[g]) begin
            taken   <= '0;
          end
        end
      end
    end
  endgenerate

  // receive error counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_data <= '0;
      err_idle <= '0;
    end else begin
      if (events.rxerr_data) err_data <= sat_inc16(err_data);
      if (events.rxerr_idle) err_idle <= sat_inc16(err_idle);
    end
  end

  // datapath steering in loopback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      descr_in    <= 8'h00;
      line_tx     <= 8'h00;
      tx_power_dn <= 1'b0;
    end else begin
      descr_in    <= loopback ? scr_data : line_rx;
      line_tx     <= loopback ? 8'h00 : scr_data;
      tx_power_dn <= loopback;
    end
  end

  // collision: test mode follows tx_en after a short count, one cycle
  // is well inside 512 bit times at every speed so the bound is comfortably met
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_cnt <= '0;
      col     <= 1'b0;
    end else if (col_test) begin
      if (!tx_en) begin
        col_cnt <= '0;
        col     <= 1'b0;
      end else if (col_cnt >= COL_W'(pldc_pkg::COL_DELAY_CYC - 1)) begin
        col <= 1'b1;
      end else begin
        col_cnt <= col_cnt + 1'b1;
      end
    end else begin
      col_cnt <= '0;
      col     <= loopback ? 1'b0 : col_raw;
    end
  end
endmodule

// file: pldc_checker.sv
`timescale 1ns/10ps
module pldc_checker (
  input wire logic                   pclk,        // clock
  input wire logic                   presetn,     // reset, low
  input wire logic                   psel,        // apb
  input wire logic                   penable,     // apb
  input wire logic                   pwrite,      // apb
  input wire logic [11:0]            paddr,       // apb
  input wire logic [31:0]            prdata,      // apb
  input wire logic                   pready,      // apb
  input wire logic [7:0]             scr_data,    // scrambler
  input wire logic [7:0]             descr_in,    // descrambler
  input wire logic [7:0]             line_tx,     // line data
  input wire logic                   tx_power_dn, // line off
  input wire logic                   tx_en,       // mac
  input wire logic                   col,         // mac
  input wire pldc_pkg::pldc_status_t stat_in      // status
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // two cycles of loopback, so the registered paths have settled
  sequence s_lb;
    tx_power_dn && $past(tx_power_dn);
  endsequence
  sequence s_st;
    pready && !pwrite && paddr == pldc_pkg::OFF_STATUS;
  endsequence
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  property p_loop;
    s_lb |-> descr_in == $past(scr_data);
  endproperty
  property p_quiet;
    s_lb |-> line_tx == 8'h00;
  endproperty
  // three quiet cycles of tx_en rule out a collision-test pulse still draining
  property p_col;
    s_lb |-> $past(tx_en) || $past(tx_en, 2) || $past(tx_en, 3) || !col;
  endproperty
  property p_xov;
    s_st |-> prdata[7:4] == $past({stat_in.crossed_pair_b_status, stat_in.crossed_pair_a_status});
  endproperty
  property p_pol1;
    s_st |-> $past(stat_in.an_done) || !prdata[1];
  endproperty
  property p_pol023;
    s_st |-> $past(stat_in.link_up) || {prdata[3:2], prdata[0]} == 3'h0;
  endproperty
  property p_pol;
    s_st |-> !$past(stat_in.link_up && stat_in.an_done) || prdata[3:0] == $past(stat_in.pol_flip);
  endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
  a_loop: assert property (p_loop) else $error("loopback data wrong");
  a_col: assert property (p_col) else $error("collision in loopback");
  a_quiet: assert property (p_quiet) else $error("line driven in loopback");
  a_xov: assert property (p_xov) else $error("crossover fields wrong");
  a_pol: assert property (p_pol) else $error("polarity bits wrong");
  a_pol1: assert property (p_pol1) else $error("channel one polarity ungated");
  a_pol023: assert property (p_pol023) else $error("polarity ungated");
endmodule
bind pldc_diag pldc_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .scr_data, .descr_in, .line_tx, .tx_power_dn, .tx_en, .col, .stat_in);

// file: pldc_mac_model.sv
`timescale 1ns/10ps
module pldc_mac_model (
  input  wire logic              pclk,     // bus clock
  output pldc_pkg::pldc_events_t events,   // count strobes
  output logic [7:0]             scr_data  // scrambler output
);
  // data moves every cycle, so a stale loopback copy is caught
  initial begin
    events = '0;
    scr_data = 8'h5a;
    forever @(posedge pclk) scr_data <= scr_data + 8'h01;
  end
  task automatic pulse(input pldc_pkg::pldc_events_t e, input int n);
    repeat (n) begin
      @(posedge pclk);
      events <= e;
      @(posedge pclk);
      events <= '0;
    end
  endtask
endmodule

// file: tb_pldc_diag.sv
`timescale 1ns/10ps
module tb_pldc_diag;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_power_dn, tx_en, col_raw, col;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  scr_data, line_rx, descr_in, line_tx;
  pldc_pkg::pldc_status_t stat_in;
  pldc_pkg::pldc_events_t events;
  int          error_cnt, n_checks;
  pldc_diag dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .scr_data, .line_rx, .descr_in, .line_tx, .tx_power_dn, .tx_en, .col_raw, .col,
    .stat_in, .events);
  pldc_mac_model mac (.pclk, .events, .scr_data);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int t;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) error_cnt++;
    r = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk(r, e);
  endtask
  task automatic st(input logic [9:0] s, input logic [31:0] e);
    stat_in <= s;
    rd(pldc_pkg::OFF_STATUS, e);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, tx_en, col_raw, paddr, pwdata} = '0;
    line_rx = 8'h3c;
    stat_in = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(pldc_pkg::OFF_CTRL, 32'h0);
    rd(pldc_pkg::OFF_GOOD_LO, 32'h0);
    rd(12'h0fc, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      a = pldc_pkg::OFF_GOOD_LO + 12'(16 * i);
      mac.pulse(5'h10 >> i, 3);
      rd(a, 32'h3);
      mac.pulse(5'h10 >> i, 2);
      rd(a + 12'h4, 32'h0);
      rd(a + 12'h8, 32'h0);
      rd(a, 32'h2);
    end
    mac.pulse(5'h02, 4);
    mac.pulse(5'h01, 1);
    rd(pldc_pkg::OFF_RXE_DATA, 32'h4);
    rd(pldc_pkg::OFF_RXE_IDLE, 32'h1);
    $display("counter test done");
    col_raw <= 1'b1;
    apb(1'b1, pldc_pkg::OFF_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk({23'h0, tx_power_dn, line_tx}, 32'h100);
    chk(32'(col), 32'h0);
    apb(1'b1, pldc_pkg::OFF_CTRL, 32'h3);
    tx_en <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(col), 32'h1);
    tx_en <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(col), 32'h0);
    apb(1'b1, pldc_pkg::OFF_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk({23'h0, col, descr_in}, 32'h13c);
    $display("loopback test done");
    st(10'h3d8, 32'h090);
    st(10'h3d9, 32'h292);
    st(10'h3da, 32'h19d);
    st(10'h3db, 32'h39f);
    $display("status test done");
    conclude();
  end
  initial begin
    repeat (4000) @(posedge pclk);
    error_cnt++;
    conclude();
  end
endmodule
